// File: hw/indirect_addr_pkg.sv
// package: modes, states and constants of the indirect address generator
package indirect_addr_pkg;
   // addressing modes that the sequencer may request
   typedef enum logic [1:0] {
      mode_jump_abs = 2'h0,
      mode_jump_ind = 2'h1,
      mode_x_ind = 2'h2,
      mode_ind_y = 2'h3
   } mode_t;

   // sequencer states, one-hot
   typedef enum logic [5:0] {
      st_idle = 6'h01,
      st_opc = 6'h02,
      st_oplo = 6'h04,
      st_ophi = 6'h08,
      st_ptrlo = 6'h10,
      st_ptrhi = 6'h20
   } state_t;

   localparam logic [7:0] zero_page = 8'h00;
   localparam logic [15:0] addr_reset = 16'h0000;
   localparam logic [7:0] byte_reset = 8'h00;
   localparam logic [15:0] one_step = 16'h0001;
   localparam logic [15:0] two_step = 16'h0002;
   // bus reads per operation, opcode included
   localparam logic [2:0] reads_jump_abs = 3'h3;
   localparam logic [2:0] reads_jump_ind = 3'h5;
   localparam logic [2:0] reads_indexed = 3'h4;
endpackage : indirect_addr_pkg

// File: hw/byte_adder.sv
// unsigned 8-bit adder with carry in and carry out
`timescale 1ns/100ps
`default_nettype none
module byte_adder (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   output logic [7:0] sum,
   output logic cout
);
   logic [8:0] full;

   // nine bits wide so the carry is kept, not silently lost
   always_comb begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      sum = full[7:0];
      cout = full[8];
   end
endmodule : byte_adder
`default_nettype wire

// File: hw/indirect_address_generator.sv
// effective-address generator for absolute and indexed indirect modes
//
// Summary of operation
// [RULE1] an absolute indirect jump_op fetches opcode, pointer low and high.
// [RULE2] indirect jump reads target low at the pointer, high at pointer+1.
// [RULE3] a plain absolute jump_op loads its two operand bytes as the target.
// [RULE4] X-indexed indirect adds X to the zero-page operand, dropping carry.
// [RULE5] X-indexed indirect reads low at the pointer, high at pointer+1.
// [RULE6] Y-indexed indirect adds Y to the byte at the operand address.
// [RULE7] the carry of that low sum is added to the next zero-page byte.
// [RULE8] index sums are unsigned 8 bit and zero-page increments wrap.
`timescale 1ns/100ps
`default_nettype none
module indirect_address_generator
   import indirect_addr_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [1:0] mode,
   input wire logic [15:0] instr_addr,
   input wire logic [7:0] x_index,
   input wire logic [7:0] y_index,
   output logic mem_req,
   output logic [15:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   output logic busy,
   output logic done,
   output logic pc_load,
   output logic [15:0] eff_addr,
   output logic [7:0] opcode
);
   state_t state;
   mode_t mode_q;
   logic [15:0] pc;
   logic [7:0] x_q;
   logic [7:0] y_q;
   logic [7:0] op_lo;
   logic [15:0] ptr_addr;
   logic [7:0] ea_lo;
   logic carry;
   logic ack_ok;
   logic is_jump;
   logic [15:0] next_addr;
   logic [7:0] idx_b;
   logic [7:0] idx_sum;
   logic idx_cout;
   logic [7:0] inc_a;
   logic inc_cin;
   logic [7:0] inc_sum;
   logic inc_cout;

   assign ack_ok = mem_req & mem_ack;
   assign is_jump = (mode_q == mode_jump_abs) || (mode_q == mode_jump_ind);

   // index adder: X at operand time, Y once the base byte arrives
   always_comb begin
      idx_b = y_q;
      if (state == st_oplo) idx_b = (mode_q == mode_x_ind) ? x_q : byte_reset;
   end

   byte_adder u_index_add (
      .a(mem_rdata),
      .b(idx_b),
      .cin(1'b0),
      .sum(idx_sum),
      .cout(idx_cout)
   );

   // increment adder: pointer step, or high byte plus low-byte carry
   always_comb begin
      inc_a = ptr_addr[7:0];
      inc_cin = 1'b1;
      if (state == st_ptrhi) begin
         inc_a = mem_rdata;
         inc_cin = carry; // RULE7
      end
   end

   byte_adder u_inc_add (
      .a(inc_a),
      .b(byte_reset),
      .cin(inc_cin),
      .sum(inc_sum),
      .cout(inc_cout)
   );

   // address of the byte that the current state needs
   always_comb begin
      unique case (state)
         st_opc: next_addr = pc; // RULE1
         st_oplo: next_addr = pc + one_step; // RULE1
         st_ophi: next_addr = pc + two_step; // RULE1
         default: next_addr = ptr_addr;
      endcase
   end

   // sequencer
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state <= st_idle;
      end else begin
         unique case (state)
            st_idle: if (start) state <= st_opc;
            st_opc: if (ack_ok) state <= st_oplo;
            st_oplo: if (ack_ok) state <= is_jump ? st_ophi : st_ptrlo;
            st_ophi: if (ack_ok) begin
               state <= mode_q == mode_jump_abs ? st_idle : st_ptrlo; // RULE3
            end
            st_ptrlo: if (ack_ok) state <= st_ptrhi;
            st_ptrhi: if (ack_ok) state <= st_idle;
            default: state <= st_idle;
         endcase
      end
   end

   // bus request: raised one cycle after each non-idle state entry, dropped on ack
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mem_req <= 1'b0;
         mem_addr <= addr_reset;
      end else if (ack_ok) begin
         mem_req <= 1'b0;
      end else if (!mem_req && state != st_idle) begin
         mem_req <= 1'b1;
         mem_addr <= next_addr;
      end
   end

   // request latch: the sequencer need not hold its inputs
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mode_q <= mode_jump_abs;
         pc <= addr_reset;
         x_q <= byte_reset;
         y_q <= byte_reset;
      end else if (state == st_idle && start) begin
         mode_q <= mode_t'(mode);
         pc <= instr_addr;
         x_q <= x_index;
         y_q <= y_index;
      end
   end

   // pointer and byte capture
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         opcode <= byte_reset;
         op_lo <= byte_reset;
         ptr_addr <= addr_reset;
         ea_lo <= byte_reset;
         carry <= 1'b0;
      end else if (ack_ok) begin
         unique case (state)
            st_opc: opcode <= mem_rdata;
            st_oplo: begin
               op_lo <= mem_rdata;
               // carry out of the X sum is discarded on purpose
               ptr_addr <= {zero_page, idx_sum}; // RULE4 RULE8
            end
            st_ophi: ptr_addr <= {mem_rdata, op_lo}; // RULE2
            st_ptrlo: begin
               ea_lo <= (mode_q == mode_ind_y) ? idx_sum : mem_rdata; // RULE6
               carry <= (mode_q == mode_ind_y) & idx_cout; // RULE7
               // jump pointer steps over 16 bits, zero-page pointer wraps
               ptr_addr <= is_jump ?
                  {ptr_addr[15:8] + {7'h00, inc_cout}, inc_sum} :
                  {zero_page, inc_sum}; // RULE5 RULE8
            end
            default: carry <= carry;
         endcase
      end
   end

   // result: one-cycle done with the address held until the next one
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         busy <= 1'b0;
         done <= 1'b0;
         pc_load <= 1'b0;
         eff_addr <= addr_reset;
      end else begin
         done <= 1'b0;
         if (state == st_idle && start) busy <= 1'b1;
         if (ack_ok && state == st_ophi && mode_q == mode_jump_abs) begin
            eff_addr <= {mem_rdata, op_lo}; // RULE3
            pc_load <= 1'b1;
            done <= 1'b1;
            busy <= 1'b0;
         end
         if (ack_ok && state == st_ptrhi) begin
            eff_addr <= {inc_sum, ea_lo}; // RULE2 RULE5 RULE7
            pc_load <= is_jump;
            done <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
   // checking helpers: reads per operation and raw bytes seen
   logic [2:0] read_cnt;
   logic [7:0] lo_raw;
   logic [7:0] lo_ptr;
   logic [7:0] zp_first;
   logic [15:0] jmp_ptr;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         read_cnt <= 3'h0;
         lo_raw <= byte_reset;
         lo_ptr <= byte_reset;
         zp_first <= byte_reset;
         jmp_ptr <= addr_reset;
      end else begin
         if (state == st_idle && start) read_cnt <= 3'h0;
         else if (ack_ok) read_cnt <= read_cnt + 3'h1;
         if (ack_ok && state == st_oplo) lo_ptr <= mem_rdata + x_q;
         if (ack_ok && state == st_ophi) jmp_ptr <= {mem_rdata, op_lo};
         if (ack_ok && state == st_ptrlo) lo_raw <= mem_rdata;
         if (ack_ok && state == st_ptrlo) zp_first <= mem_addr[7:0];
      end
   end
   property p_jump_ind_reads;
      @(posedge core_clk) disable iff (reset)
      done && mode_q == mode_jump_ind |-> read_cnt == reads_jump_ind;
   endproperty
   a_jump_ind_reads: assert property (p_jump_ind_reads) // RULE1
      else $error("indirect jump did not take five reads");

   property p_jump_ind_hi;
      @(posedge core_clk) disable iff (reset)
      state == st_ptrhi && mem_req && mode_q == mode_jump_ind
         |-> mem_addr == jmp_ptr + one_step;
   endproperty
   a_jump_ind_hi: assert property (p_jump_ind_hi) // RULE2
      else $error("indirect jump high byte not read at pointer plus one");

   property p_jump_abs;
      @(posedge core_clk) disable iff (reset)
      done && mode_q == mode_jump_abs |->
         pc_load && read_cnt == reads_jump_abs && eff_addr[7:0] == op_lo;
   endproperty
   a_jump_abs: assert property (p_jump_abs) // RULE3
      else $error("absolute jump target wrong or pointer read made");

   property p_x_ptr;
      @(posedge core_clk) disable iff (reset)
      state == st_ptrlo && mem_req && mode_q == mode_x_ind
         |-> mem_addr == {zero_page, lo_ptr};
   endproperty
   a_x_ptr: assert property (p_x_ptr) // RULE4
      else $error("X indexed pointer not operand plus X in page zero");

   property p_zp_reads;
      @(posedge core_clk) disable iff (reset)
      (state == st_ptrlo || state == st_ptrhi) && mem_req && !is_jump
         |-> mem_addr[15:8] == zero_page;
   endproperty
   a_zp_reads: assert property (p_zp_reads) // RULE5
      else $error("pointer read left page zero");

   property p_y_lo;
      @(posedge core_clk) disable iff (reset)
      done && mode_q == mode_ind_y |-> eff_addr[7:0] == 8'(lo_raw + y_q);
   endproperty
   a_y_lo: assert property (p_y_lo) // RULE6
      else $error("Y indexed low byte is not base plus Y");

   property p_y_hi;
      @(posedge core_clk) disable iff (reset)
      state == st_ptrhi && ack_ok && mode_q == mode_ind_y |=>
         eff_addr[15:8] ==
            8'($past(mem_rdata) + ({1'b0, lo_raw} + {1'b0, y_q}) / 9'h100);
   endproperty
   a_y_hi: assert property (p_y_hi) // RULE7
      else $error("Y indexed high byte missed the low-byte carry");
   // second read must sit one above the first, wrapped inside page zero
   property p_zp_wrap;
      @(posedge core_clk) disable iff (reset)
      $rose(mem_req) && state == st_ptrhi && !is_jump
         |-> mem_addr == {zero_page, 8'(zp_first + 8'h01)};
   endproperty
   a_zp_wrap: assert property (p_zp_wrap) // RULE8
      else $error("second pointer byte not at wrapped pointer plus one");
   property p_idx_reads;
      @(posedge core_clk) disable iff (reset)
      done && !is_jump |-> read_cnt == reads_indexed && !pc_load;
   endproperty
   a_idx_reads: assert property (p_idx_reads) // RULE4
      else $error("indexed mode read count wrong");

   c_jump_ind: cover property (@(posedge core_clk) disable iff (reset)
      done && mode_q == mode_jump_ind);
   c_x_wrap: cover property (@(posedge core_clk) disable iff (reset)
      state == st_ptrhi && mode_q == mode_x_ind && ptr_addr[7:0] == 8'h00);
   c_y_carry: cover property (@(posedge core_clk) disable iff (reset)
      state == st_ptrhi && mode_q == mode_ind_y && carry);
endmodule : indirect_address_generator
`default_nettype wire

// File: dv/memory_model.sv
// behavioural byte memory answering the generator's reads
`timescale 1ns/100ps
`default_nettype none
module memory_model (
   input wire logic core_clk,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic [3:0] wait_cycles,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [3:0] waited;

   initial begin
      mem_ack = 1'b0;
      mem_rdata = 8'h00;
      waited = 4'h0;
   end

   // one read at a time; data flips after an ack and while idle, but holds through wait cycles
   always @(posedge core_clk) begin
      if (mem_ack) begin
         mem_ack <= #1 1'b0;
         mem_rdata <= #1 ~mem_rdata;
      end else if (mem_req && waited >= wait_cycles) begin
         mem_ack <= #1 1'b1;
         mem_rdata <= #1 mem[mem_addr];
         waited <= #1 4'h0;
      end else if (mem_req) begin
         waited <= #1 waited + 4'h1;
      end else begin
         mem_rdata <= #1 ~mem_rdata;
      end
   end
endmodule : memory_model
`default_nettype wire

// File: dv/test_indirect_address_generator.sv
// self-checking bench for the indirect address generator
`timescale 1ns/100ps
`default_nettype none
module test_indirect_address_generator;
   import indirect_addr_pkg::*;
   logic core_clk, reset, start, mem_req, mem_ack, busy, done, pc_load;
   logic [1:0] mode;
   logic [15:0] instr_addr, mem_addr, eff_addr;
   logic [7:0] x_index, y_index, mem_rdata, opcode;
   logic [3:0] wait_cycles;
   logic [15:0] rd_addr [$];
   int errors;
   int comparisons;

   indirect_address_generator indirect_address_generator_inst (
      .core_clk(core_clk), .reset(reset), .start(start), .mode(mode),
      .instr_addr(instr_addr), .x_index(x_index), .y_index(y_index),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .busy(busy), .done(done),
      .pc_load(pc_load), .eff_addr(eff_addr), .opcode(opcode));

   memory_model memory_model_inst (
      .core_clk(core_clk), .mem_req(mem_req), .mem_addr(mem_addr),
      .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // log of every read the memory side accepted
   always @(posedge core_clk) begin
      if (mem_req === 1'b1 && mem_ack === 1'b1) begin
         rd_addr.push_back(mem_addr);
      end
   end

   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic poke(input logic [15:0] a, input logic [7:0] b);
      memory_model_inst.mem[a] = b;
   endtask : poke

   task automatic put3(input logic [15:0] a, input logic [7:0] b0,
         input logic [7:0] b1, input logic [7:0] b2);
      poke(a, b0);
      poke(a + 16'h0001, b1);
      poke(a + 16'h0002, b2);
   endtask : put3

   // one request; returns in the cycle after the done pulse
   task automatic run_op(input mode_t m, input logic [15:0] ia,
         input logic [7:0] xi, input logic [7:0] yi);
      int n;
      n = 0;
      rd_addr.delete();
      @(posedge core_clk);
      #1;
      mode = m;
      instr_addr = ia;
      x_index = xi;
      y_index = yi;
      start = 1'b1;
      @(posedge core_clk);
      #1;
      start = 1'b0;
      check("busy", {15'h0000, busy}, 16'h0001);
      while (done !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check("done", {15'h0000, done}, 16'h0001);
      check("busy at done", {15'h0000, busy}, 16'h0000);
      check("mem_req at done", {15'h0000, mem_req}, 16'h0000);
      // done is a single-cycle pulse; the result must stay behind it
      @(posedge core_clk);
      #1;
      check("done pulse", {15'h0000, done}, 16'h0000);
   endtask : run_op

   task automatic result(input logic [15:0] eff, input logic pcl,
         input int reads);
      check("eff_addr", eff_addr, eff);
      check("pc_load", {15'h0000, pc_load}, {15'h0000, pcl});
      check("reads", 16'(rd_addr.size()), 16'(reads));
   endtask : result

   task automatic test_plain_jump();
      put3(16'h0200, 8'h4C, 8'h34, 8'h12);
      run_op(mode_jump_abs, 16'h0200, 8'h00, 8'h00);
      result(16'h1234, 1'b1, 3);
      check("opcode", {8'h00, opcode}, 16'h004C);
      check("last fetch", rd_addr[2], 16'h0202);
      $display("test plain jump done");
   endtask : test_plain_jump

   task automatic test_indirect_jump();
      wait_cycles = 4'h3; // slow memory stretches every read
      put3(16'h0300, 8'h6C, 8'h26, 8'h03);
      put3(16'h0326, 8'h65, 8'hF2, 8'h00);
      run_op(mode_jump_ind, 16'h0300, 8'h00, 8'h00);
      result(16'hF265, 1'b1, 5);
      check("ptr low read", rd_addr[3], 16'h0326);
      check("ptr high read", rd_addr[4], 16'h0327);
      wait_cycles = 4'h0;
      put3(16'h0310, 8'h6C, 8'hFF, 8'h12);
      put3(16'h12FF, 8'h11, 8'h22, 8'h00);
      run_op(mode_jump_ind, 16'h0310, 8'h00, 8'h00);
      result(16'h2211, 1'b1, 5);
      check("ptr high read", rd_addr[4], 16'h1300);
      $display("test indirect jump done");
   endtask : test_indirect_jump

   task automatic test_x_indirect();
      put3(16'h0400, 8'h81, 8'hF0, 8'h00);
      put3(16'h0010, 8'h56, 8'hF3, 8'h00);
      run_op(mode_x_ind, 16'h0400, 8'h20, 8'h00);
      result(16'hF356, 1'b0, 4);
      check("x pointer", rd_addr[2], 16'h0010);
      check("x pointer high", rd_addr[3], 16'h0011);
      put3(16'h0400, 8'h81, 8'hFE, 8'h00);
      poke(16'h00FF, 8'h78);
      poke(16'h0000, 8'h9A);
      run_op(mode_x_ind, 16'h0400, 8'h01, 8'h00);
      result(16'h9A78, 1'b0, 4);
      check("x wrap read", rd_addr[3], 16'h0000);
      $display("test x indirect done");
   endtask : test_x_indirect

   task automatic test_y_indirect();
      put3(16'h0500, 8'h91, 8'hEA, 8'h00);
      put3(16'h00EA, 8'hF0, 8'h3F, 8'h00);
      run_op(mode_ind_y, 16'h0500, 8'h00, 8'h08);
      result(16'h3FF8, 1'b0, 4);
      check("y pointer", rd_addr[2], 16'h00EA);
      check("y pointer high", rd_addr[3], 16'h00EB);
      run_op(mode_ind_y, 16'h0500, 8'h00, 8'h20);
      result(16'h4010, 1'b0, 4);
      put3(16'h0500, 8'h91, 8'hFF, 8'h00);
      poke(16'h00FF, 8'h80);
      poke(16'h0000, 8'h12);
      run_op(mode_ind_y, 16'h0500, 8'h00, 8'h90);
      result(16'h1310, 1'b0, 4);
      check("y wrap read", rd_addr[3], 16'h0000);
      $display("test y indirect done");
   endtask : test_y_indirect

   // reset in the middle of an indirect jump, then a clean plain jump
   task automatic test_reset_mid();
      put3(16'h0200, 8'h4C, 8'h34, 8'h12);
      @(posedge core_clk);
      #1;
      mode = mode_jump_ind;
      instr_addr = 16'h0300;
      start = 1'b1;
      @(posedge core_clk);
      #1;
      start = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      reset = 1'b1;
      #1;
      check("busy in mid reset", {15'h0000, busy}, 16'h0000);
      check("mem_req in mid reset", {15'h0000, mem_req}, 16'h0000);
      check("eff_addr in mid reset", eff_addr, 16'h0000);
      check("pc_load in mid reset", {15'h0000, pc_load}, 16'h0000);
      check("opcode in mid reset", {8'h00, opcode}, 16'h0000);
      @(posedge core_clk);
      #1;
      reset = 1'b0;
      run_op(mode_jump_abs, 16'h0200, 8'h00, 8'h00);
      result(16'h1234, 1'b1, 3);
      $display("test reset mid run done");
   endtask : test_reset_mid

   // main sequence
   initial begin
      errors = 0;
      comparisons = 0;
      reset = 1'b1;
      start = 1'b0;
      mode = 2'h0;
      instr_addr = 16'h0000;
      x_index = 8'h00;
      y_index = 8'h00;
      wait_cycles = 4'h0;
      repeat (3) @(posedge core_clk);
      #1;
      check("busy in reset", {15'h0000, busy}, 16'h0000);
      reset = 1'b0;
      test_plain_jump();
      test_indirect_jump();
      test_x_indirect();
      test_y_indirect();
      test_reset_mid();
      final_report();
   end

   // watchdog, far beyond the roughly 160 cycles the tests need
   initial begin
      #100000;
      errors++;
      $display("watchdog expired");
      final_report();
   end
endmodule : test_indirect_address_generator
`default_nettype wire
